// *** design/bl_pkg.sv ***
// Shared constants, types and helpers for the backlight brightness control
package bl_pkg;

    // Clock and timing
    localparam int CLK_HZ       = 125_000_000;
    localparam int PWM_STEPS    = 1024;
    localparam int PWM_FMIN_HZ  = 229;
    localparam int PWM_FMAX_HZ  = 19531;
    localparam int DIV_SLOW     = CLK_HZ / (PWM_FMIN_HZ * PWM_STEPS);
    localparam int DIV_FAST     = CLK_HZ / (PWM_FMAX_HZ * PWM_STEPS);
    localparam int IN_FMIN_HZ   = 100;
    localparam int IN_FMAX_HZ   = 25_000;
    localparam int IN_SPAN_CYC  = CLK_HZ / IN_FMIN_HZ;
    localparam int STBY_MS      = 50;
    localparam int STBY_CYCLES  = (CLK_HZ / 1000) * STBY_MS;
    localparam int ALS_CONV_MS  = 500;
    localparam int ALS_GATE_CYC = (CLK_HZ / 1000) * ALS_CONV_MS;

    // Sink current scale: code times step gives microamps
    localparam int CUR_FULL_UA  = 60_000;
    localparam int CUR_STEP_UA  = 230;
    localparam int CUR_DEF_UA   = 20_000;
    localparam logic [7:0] CUR_DEFAULT = 8'(CUR_DEF_UA / CUR_STEP_UA);

    localparam int NSINK        = 7;
    localparam int MAIN_MIN     = 4;
    localparam logic [9:0] DUTY_MAX = 10'h3FF;
    localparam int CURVE_FRAC   = 2;
    localparam int ALS_GAIN_FRAC = 4;
    localparam int ALS_SCALE_SH = 8;
    localparam int TEMP_DERATE_SH = 1;

    // Register byte addresses
    localparam logic [11:0] REG_CONFIG      = 12'h000;
    localparam logic [11:0] REG_MAIN_BRIGHT = 12'h004;
    localparam logic [11:0] REG_SUB_BRIGHT  = 12'h008;
    localparam logic [11:0] REG_MAIN_CUR    = 12'h00C;
    localparam logic [11:0] REG_SUB_CUR     = 12'h010;
    localparam logic [11:0] REG_FAULT       = 12'h014;
    localparam logic [11:0] REG_STATE       = 12'h018;
    localparam logic [11:0] REG_LIGHT       = 12'h01C;
    localparam logic [11:0] REG_NVM_CMD     = 12'h020;
    localparam logic [11:0] REG_SHADOW      = 12'h040;
    localparam logic [11:0] REG_SHADOW_END  = 12'h080;

    // Config register fields
    localparam int CFB_MODE = 0;
    localparam int CFB_SEL  = 1;
    localparam int CFB_CUR  = 2;
    localparam int CFB_STAG = 3;
    localparam int CFB_ALS  = 4;
    localparam logic [7:0] CONFIG_RESET = 8'h02;

    // PWM source, {mode, select}
    localparam logic [1:0] SRC_DIRECT = 2'b11;
    localparam logic [1:0] SRC_DUTY   = 2'b01;
    localparam logic [1:0] SRC_BRIGHT = 2'b10;
    localparam logic [1:0] SRC_MIXED  = 2'b00;

    // Nonvolatile byte indexes
    localparam int NVM_DEPTH   = 16;
    localparam int NV_CUR_MAIN = 0;
    localparam int NV_CUR_SUB  = 1;
    localparam int NV_X1       = 2;
    localparam int NV_X2       = 3;
    localparam int NV_S0       = 4;
    localparam int NV_S1       = 5;
    localparam int NV_S2       = 6;
    localparam int NV_CFG      = 7;
    localparam int NV_TEMP     = 8;
    localparam int NV_OPEN     = 9;
    localparam int NV_SHORT    = 10;
    localparam int NV_ALS_PRE  = 11;
    localparam int NV_ALS_GAIN = 12;
    localparam int NV_ALS_OFS  = 13;
    localparam int NVB_CONF    = 0;
    localparam int NVB_FREQ    = 2;
    localparam int NVB_POL     = 5;
    localparam int NVB_SLOPE   = 6;

    localparam logic [NVM_DEPTH-1:0][7:0] NVM_RESET = {
        8'h00, 8'h00, 8'h20, 8'h10, 8'h02, 8'hC0, 8'h10, 8'hA0,
        8'h32, 8'h10, 8'h10, 8'h10, 8'hC0, 8'h40, CUR_DEFAULT, CUR_DEFAULT};

    typedef enum logic [0:0] {ST_LOAD, ST_RUN} ctl_state_t;

    // Three-segment transfer, 8-bit brightness to 10-bit duty
    function automatic logic [9:0] curve(input logic [7:0] x, input logic [7:0] x1, input logic [7:0] x2,
                                         input logic [7:0] s0, input logic [7:0] s1, input logic [7:0] s2);
        logic [17:0] y1;
        logic [17:0] y2;
        logic [17:0] y;
        y1 = ({10'h000, x1} * {10'h000, s0}) >> CURVE_FRAC;
        y2 = y1 + (({10'h000, 8'(x2 - x1)} * {10'h000, s1}) >> CURVE_FRAC);
        if (x < x1) begin
            y = ({10'h000, x} * {10'h000, s0}) >> CURVE_FRAC;
        end else if (x < x2) begin
            y = y1 + (({10'h000, 8'(x - x1)} * {10'h000, s1}) >> CURVE_FRAC);
        end else begin
            y = y2 + (({10'h000, 8'(x - x2)} * {10'h000, s2}) >> CURVE_FRAC);
        end
        return (y > {8'h00, DUTY_MAX}) ? DUTY_MAX : y[9:0];
    endfunction

    // Phase spacing for 4 to 7 main strings
    function automatic logic [9:0] stagger_step(input logic [1:0] conf);
        case (conf)
            2'b00:   return 10'(PWM_STEPS / 4);
            2'b01:   return 10'(PWM_STEPS / 5);
            2'b10:   return 10'(PWM_STEPS / 6);
            default: return 10'(PWM_STEPS / 7);
        endcase
    endfunction

endpackage

// *** design/pwm_duty_meter.sv ***
// Duty-cycle meter for the external PWM input
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_meter
    import bl_pkg::*;
#(
    parameter int CNT_W    = 24,
    parameter int STBY_CYC = STBY_CYCLES,
    parameter int SPAN_CYC = IN_SPAN_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pwm_pin,
    output logic            pin_level,
    output logic [9:0]      duty,
    output logic            idle_low
);

    typedef struct packed {
        logic [1:0]       sync;
        logic             prev;
        logic [CNT_W-1:0] hcnt;
        logic [CNT_W-1:0] pcnt;
        logic [CNT_W-1:0] run;
        logic [CNT_W-1:0] per;
        logic [CNT_W:0]   rem;
        logic [3:0]       step;
        logic [9:0]       quo;
        logic [9:0]       duty;
        logic             idle;
    } meter_t;

    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_TOP  = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] STBY_LIM = CNT_W'(STBY_CYC);
    localparam logic [CNT_W-1:0] SPAN_LIM = CNT_W'(SPAN_CYC);
    localparam logic [3:0]       DIV_BITS = 4'hA;

    meter_t s;
    meter_t n;
    logic   lvl;
    logic [CNT_W+1:0] r2;

    assign lvl       = s.sync[1];
    assign pin_level = s.prev;
    assign duty      = s.duty;
    assign idle_low  = s.idle;

    always_comb begin
        n = s;
        r2 = {s.rem, 1'b0};
        n.sync = {s.sync[0], pwm_pin};
        n.prev = lvl;
        if (s.pcnt != CNT_TOP) n.pcnt = s.pcnt + CNT_ONE;
        if (lvl && s.hcnt != CNT_TOP) n.hcnt = s.hcnt + CNT_ONE;
        if (s.run != CNT_TOP) n.run = s.run + CNT_ONE;
        if (lvl != s.prev) n.run = '0;
        if (s.step != '0) begin
            n.step = s.step - 4'h1;
            if (r2 >= {2'b00, s.per}) begin
                n.rem = (CNT_W+1)'(r2 - {2'b00, s.per});
                n.quo = {s.quo[8:0], 1'b1};
            end else begin
                n.rem = r2[CNT_W:0];
                n.quo = {s.quo[8:0], 1'b0};
            end
            if (s.step == 4'h1) n.duty = n.quo;
        end
        if (lvl && !s.prev) begin
            if (s.step == '0 && s.pcnt != '0) begin
                n.per  = s.pcnt;
                n.rem  = {1'b0, s.hcnt};
                n.quo  = '0;
                n.step = DIV_BITS;
            end
            n.pcnt = CNT_ONE;
            n.hcnt = CNT_ONE;
            n.idle = 1'b0;
        end
        // level held past the slowest period
        if (s.run >= SPAN_LIM) begin
            n.duty = lvl ? DUTY_MAX : '0;
            n.step = '0;
        end
        if (!lvl && s.run >= STBY_LIM) n.idle = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule
`default_nettype wire

// *** design/backlight_brightness_control.sv ***
// Backlight brightness control: APB registers, PWM sources, stagger, faults
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module backlight_brightness_control
    import bl_pkg::*;
#(
    parameter int STBY_CYC = STBY_CYCLES,
    parameter int ALS_GATE = ALS_GATE_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              pwm_in,
    input  wire logic              light_freq_input,
    input  wire logic              proto_sel,
    input  wire logic [7:0]        temp_code,
    input  wire logic [NSINK-1:0]  open_flag,
    input  wire logic [NSINK-1:0]  short_flag,
    input  wire logic              fault_n_i,
    output logic                   fault_n_o,
    output logic                   fault_n_oe,
    output logic [NSINK-1:0]       sink_on,
    output logic [7:0]             main_current,
    output logic [7:0]             sub_current,
    output logic [7:0]             open_thr,
    output logic [7:0]             short_thr,
    output logic                   sensor_en,
    output logic                   standby,
    output logic                   smbus_sel
);

    typedef struct packed {
        ctl_state_t                  state;
        logic [NVM_DEPTH-1:0][7:0]   nvm;
        logic [NVM_DEPTH-1:0][7:0]   shadow;
        logic [7:0]                  ctrl;
        logic [7:0]                  main_bright;
        logic [7:0]                  sub_bright;
        logic [7:0]                  main_cur;
        logic [7:0]                  sub_cur;
        logic [NSINK-1:0]            fault_open;
        logic [NSINK-1:0]            fault_short;
        logic [31:0]                 prdata;
        logic                        pslverr;
        logic [9:0]                  pwm_cnt;
        logic [9:0]                  div_cnt;
        logic [1:0]                  als_sync;
        logic                        als_prev;
        logic [15:0]                 als_cnt;
        logic [15:0]                 als_val;
        logic [25:0]                 gate_cnt;
        logic [1:0]                  proto_sync;
        logic [1:0]                  fn_sync;
        logic [NSINK-1:0]            open_s1;
        logic [NSINK-1:0]            open_s2;
        logic [NSINK-1:0]            short_s1;
        logic [NSINK-1:0]            short_s2;
        logic [NSINK-1:0]            sink_on;
        logic [9:0]                  duty;
        logic                        derate;
        logic                        sensor_en;
        logic                        standby;
        logic                        smbus_sel;
        logic                        fault_drive;
        logic [7:0]                  main_current;
        logic [7:0]                  sub_current;
    } ctl_t;

    localparam logic [25:0] GATE_LAST = 26'(ALS_GATE - 1);
    localparam logic [9:0]  DIV_SLOW_W = 10'(DIV_SLOW);
    localparam logic [9:0]  DIV_FAST_W = 10'(DIV_FAST);

    ctl_t s;
    ctl_t n;
    logic       pin_level;
    logic [9:0] meter_duty;
    logic       idle_low;

    ////////////////////////////////////////////////////////////////////////////
    // Input duty measurement

    pwm_duty_meter #(
        .CNT_W    (24),
        .STBY_CYC (STBY_CYC),
        .SPAN_CYC (IN_SPAN_CYC)
    ) u_meter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pwm_pin   (pwm_in),
        .pin_level (pin_level),
        .duty      (meter_duty),
        .idle_low  (idle_low)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux

    function automatic logic [31:0] read_word(input logic [11:0] a, input ctl_t c);
        if (a == REG_CONFIG) begin
            return {24'h0, c.ctrl};
        end else if (a == REG_MAIN_BRIGHT) begin
            return {24'h0, c.main_bright};
        end else if (a == REG_SUB_BRIGHT) begin
            return {24'h0, c.sub_bright};
        end else if (a == REG_MAIN_CUR) begin
            return {24'h0, c.main_cur};
        end else if (a == REG_SUB_CUR) begin
            return {24'h0, c.sub_cur};
        end else if (a == REG_FAULT) begin
            return {17'h0, c.fault_short, 1'b0, c.fault_open};
        end else if (a == REG_STATE) begin
            return {12'h0, ~c.fn_sync[1], c.derate, c.smbus_sel, c.standby, 6'h0, c.duty};
        end else if (a == REG_LIGHT) begin
            return {16'h0, c.als_val};
        end else if (a >= REG_SHADOW && a < REG_SHADOW_END) begin
            return {24'h0, c.shadow[a[5:2]]};
        end else begin
            return 32'h0;
        end
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (a <= REG_NVM_CMD || (a >= REG_SHADOW && a < REG_SHADOW_END));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic        wr;
    logic [1:0]  src;
    logic [1:0]  conf;
    logic        seventh_main;
    logic [9:0]  bright_duty;
    logic [9:0]  base;
    logic [19:0] prod;
    logic [15:0] als_scaled;
    logic [23:0] als_raw;
    logic [7:0]  als_factor;
    logic [9:0]  div_len;
    logic [9:0]  step;
    logic [9:0]  phase;
    logic [9:0]  rel;
    logic [NSINK-1:0] next_open;
    logic [NSINK-1:0] next_short;

    always_comb begin
        n = s;
        wr = psel && penable && pwrite;
        src = {s.ctrl[CFB_MODE], s.ctrl[CFB_SEL]};
        conf = s.shadow[NV_CFG][NVB_CONF +: 2];
        seventh_main = (conf == 2'b11);
        next_open = s.fault_open;
        next_short = s.fault_short;
        prod = '0;
        rel = '0;

        // Synchronisers for pins from outside the clock domain
        n.als_sync = {s.als_sync[0], light_freq_input};
        n.proto_sync = {s.proto_sync[0], proto_sel};
        n.fn_sync = {s.fn_sync[0], fault_n_i};
        n.open_s1 = open_flag;
        n.open_s2 = s.open_s1;
        n.short_s1 = short_flag;
        n.short_s2 = s.short_s1;
        n.smbus_sel = s.proto_sync[1];

        if (s.state == ST_LOAD) begin
            n.shadow = s.nvm;
            n.state = ST_RUN;
        end

        // APB access, read data captured in setup phase
        if (psel && !penable) begin
            n.prdata = read_word(paddr, s);
            n.pslverr = !mapped(paddr);
        end
        if (wr && mapped(paddr) && s.state == ST_RUN) begin
            if (paddr == REG_CONFIG) begin
                n.ctrl = pwdata[7:0];
            end else if (paddr == REG_MAIN_BRIGHT) begin
                n.main_bright = pwdata[7:0];
            end else if (paddr == REG_SUB_BRIGHT) begin
                n.sub_bright = pwdata[7:0];
            end else if (paddr == REG_MAIN_CUR) begin
                n.main_cur = pwdata[7:0];
            end else if (paddr == REG_SUB_CUR) begin
                n.sub_cur = pwdata[7:0];
            end else if (paddr == REG_FAULT) begin
                next_open = s.fault_open & ~pwdata[NSINK-1:0];
                next_short = s.fault_short & ~pwdata[NSINK+7:8];
            end else if (paddr == REG_NVM_CMD) begin
                if (pwdata[0]) n.nvm = s.shadow;
            end else if (paddr >= REG_SHADOW) begin
                n.shadow[paddr[5:2]] = pwdata[7:0];
            end
        end

        // per-group current, host value when selected
        n.main_current = s.ctrl[CFB_CUR] ? s.main_cur : s.shadow[NV_CUR_MAIN];
        n.sub_current = s.ctrl[CFB_CUR] ? s.sub_cur : s.shadow[NV_CUR_SUB];

        // light frequency counted over a gate window
        n.als_prev = s.als_sync[1];
        if (s.als_sync[1] && !s.als_prev && s.als_cnt != 16'hFFFF) n.als_cnt = s.als_cnt + 16'h1;
        n.gate_cnt = s.gate_cnt + 26'h1;
        if (s.gate_cnt >= GATE_LAST) begin
            n.gate_cnt = '0;
            n.als_val = s.als_cnt;
            // Edge on the gate boundary opens the next window
            n.als_cnt = {15'h0, s.als_sync[1] && !s.als_prev};
        end
        als_scaled = s.als_val >> s.shadow[NV_ALS_PRE][2:0];
        als_raw = ({8'h00, als_scaled} * {16'h0000, s.shadow[NV_ALS_GAIN]}) >> ALS_GAIN_FRAC;
        als_raw = als_raw + {16'h0000, s.shadow[NV_ALS_OFS]};
        als_factor = (als_raw > 24'h0000FF) ? 8'hFF : als_raw[7:0];
        n.sensor_en = s.shadow[NV_CFG][NVB_POL] ? s.ctrl[CFB_ALS] : !s.ctrl[CFB_ALS];

        bright_duty = curve(s.main_bright, s.shadow[NV_X1], s.shadow[NV_X2],
                            s.shadow[NV_S0], s.shadow[NV_S1], s.shadow[NV_S2]);
        case (src)
            SRC_DUTY:   base = meter_duty;
            SRC_BRIGHT: base = bright_duty;
            SRC_MIXED: begin
                prod = {10'h000, bright_duty} * {10'h000, meter_duty};
                base = prod[19:10];
            end
            default:    base = DUTY_MAX;
        endcase
        // ambient scaling on main group only
        if (s.ctrl[CFB_ALS] && src != SRC_DIRECT) begin
            prod = {10'h000, base} * {12'h000, als_factor};
            base = prod[17:8];
        end
        n.derate = temp_code > s.shadow[NV_TEMP];
        if (n.derate && src != SRC_DIRECT) base = base >> TEMP_DERATE_SH;
        n.duty = base;
        // standby when stand-alone input stays low
        n.standby = (src == SRC_DUTY) && idle_low && !s.shadow[NV_CFG][NVB_SLOPE];

        // PWM period from stored frequency select
        div_len = DIV_SLOW_W >> s.shadow[NV_CFG][NVB_FREQ +: 3];
        if (div_len < DIV_FAST_W) div_len = DIV_FAST_W;
        n.div_cnt = s.div_cnt + 10'h1;
        if (s.div_cnt >= div_len - 10'h1) begin
            n.div_cnt = '0;
            n.pwm_cnt = s.pwm_cnt + 10'h1;
        end

        // equal phase spacing for configured strings
        step = s.ctrl[CFB_STAG] ? stagger_step(conf) : 10'h000;
        phase = '0;
        for (int i = 0; i < NSINK; i++) begin
            rel = s.pwm_cnt - phase;
            if (i >= MAIN_MIN + int'(conf)) begin
                n.sink_on[i] = (i == NSINK - 1) && !seventh_main && (s.pwm_cnt < {s.sub_bright, 2'b00});
            end else if (src == SRC_DIRECT) begin
                // direct mode follows the pin level
                n.sink_on[i] = pin_level;
            end else begin
                n.sink_on[i] = !n.standby && (rel < s.duty);
            end
            phase = phase + step;
        end

        // faults on lit strings, set wins over clear
        next_open = next_open | (s.open_s2 & s.sink_on);
        next_short = next_short | (s.short_s2 & s.sink_on);
        n.fault_open = next_open;
        n.fault_short = next_short;
        n.fault_drive = |{next_open, next_short};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.state <= ST_LOAD;
            s.nvm <= NVM_RESET;
            s.shadow <= NVM_RESET;
            s.ctrl <= CONFIG_RESET;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // current code drives the linear sink DAC
    assign main_current = s.main_current;
    assign sub_current  = s.sub_current;
    assign prdata       = s.prdata;
    assign pready       = 1'b1;
    assign pslverr      = s.pslverr;
    assign sink_on      = s.sink_on;
    assign open_thr     = s.shadow[NV_OPEN];
    assign short_thr    = s.shadow[NV_SHORT];
    assign sensor_en    = s.sensor_en;
    assign standby      = s.standby;
    assign smbus_sel    = s.smbus_sel;
    assign fault_n_o    = 1'b0;
    assign fault_n_oe   = s.fault_drive;

endmodule
`default_nettype wire

// *** dv/bl_checker_assertions.sv ***
// Port-level assertions for the backlight brightness control
`timescale 1ns/1ps
`default_nettype none
module bl_checker
    import bl_pkg::*;
(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic             pslverr,
    input wire logic             pwm_in,
    input wire logic             proto_sel,
    input wire logic             fault_n_o,
    input wire logic             fault_n_oe,
    input wire logic [NSINK-1:0] sink_on,
    input wire logic [7:0]       main_current,
    input wire logic [7:0]       sub_current,
    input wire logic             standby,
    input wire logic             smbus_sel
);
    wire wr = psel && penable && pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_def_cur; $rose(presetn) |-> ##3 main_current == CUR_DEFAULT && sub_current == CUR_DEFAULT; endproperty
    a_def_cur: assert property (p_def_cur) else $error("default current");
    property p_refuse; psel && penable && paddr >= 12'h080 |-> pslverr; endproperty
    a_refuse: assert property (p_refuse) else $error("no refusal");
    property p_drain; fault_n_o == 1'h0; endproperty
    a_drain: assert property (p_drain) else $error("fault pin driven high");
    property p_clear; $fell(fault_n_oe) |-> $past(wr) || $past(wr, 2); endproperty
    a_clear: assert property (p_clear) else $error("fault cleared alone");
    property p_dark; standby |-> sink_on[3:0] == 4'h0; endproperty
    a_dark: assert property (p_dark) else $error("lit in standby");
    property p_cause; $rose(standby) |-> !$past(pwm_in, 3); endproperty
    a_cause: assert property (p_cause) else $error("standby with input high");
    property p_smb; proto_sel [*4] |-> ##1 smbus_sel; endproperty
    a_smb: assert property (p_smb) else $error("smbus not chosen");
    property p_i2c; !proto_sel [*4] |-> ##1 !smbus_sel; endproperty
    a_i2c: assert property (p_i2c) else $error("i2c not chosen");
endmodule
bind backlight_brightness_control bl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pslverr,
    .pwm_in, .proto_sel, .fault_n_o, .fault_n_oe, .sink_on, .main_current, .sub_current, .standby, .smbus_sel);
`default_nettype wire

// *** dv/pwm_source.sv ***
// Far-end PWM source, 250 link ticks per period
`timescale 1ns/1ps
`default_nettype none
module pwm_source (
    input wire logic       lclk,
    input wire logic       run,
    input wire logic [7:0] hi,
    output logic           pwm
);
    logic [7:0] cnt = 8'h00;
    always @(posedge lclk) cnt <= (cnt == 8'hF9) ? 8'h00 : cnt + 8'h01;
    assign pwm = run && cnt < hi;
endmodule
`default_nettype wire

// *** dv/backlight_brightness_control_test.sv ***
// Self-checking testbench for the backlight brightness control
`timescale 1ns/1ps
`default_nettype none
module backlight_brightness_control_test;
    import bl_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, lclk = 1'h0, run = 1'h0;
    logic        proto_sel = 1'h1, pready, pslverr, pwm_in, fault_n_o, fault_n_oe, standby, smbus_sel, err, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  temp_code = 8'h00, mc, sc, ot, st;
    logic [6:0]  open_flag = 7'h00, sink_on;
    int          errors = 0, checks = 0;
    backlight_brightness_control #(.STBY_CYC(4000), .ALS_GATE(100)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_in, .light_freq_input(lclk), .proto_sel, .temp_code,
        .open_flag, .short_flag(7'h00), .fault_n_i(fault_n_oe ? fault_n_o : 1'h1), .fault_n_o, .fault_n_oe, .sink_on,
        .main_current(mc), .sub_current(sc), .open_thr(ot), .short_thr(st), .sensor_en(se), .standby, .smbus_sel);
    pwm_source PS (.lclk, .run, .hi(8'h7D), .pwm(pwm_in));
    initial forever #4 pclk = ~pclk;
    initial begin
        #37;
        forever #80 lclk = ~lclk;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata; err = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    task automatic t_regs;
        apb(1'h0, REG_CONFIG, 32'h0);
        check(rd, 32'h02);
        check(mc, CUR_DEFAULT);
        check({ot, st}, 32'h10C0);
        check(se, 1'h0);
        apb(1'h1, REG_MAIN_CUR, 32'h11);
        apb(1'h1, REG_SUB_CUR, 32'h22);
        apb(1'h1, REG_CONFIG, 32'h06);
        cyc(3);
        check({mc, sc}, 32'h1122);
        apb(1'h1, 12'h084, 32'h5);
        apb(1'h0, 12'h084, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'h1, REG_SHADOW, 32'h33);
        apb(1'h1, REG_NVM_CMD, 32'h1);
        apb(1'h0, REG_SHADOW, 32'h0);
        check(rd, 32'h33);
        $display("regs done");
    endtask
    task automatic t_curve;
        logic [7:0] b [4] = '{8'h20, 8'h80, 8'hFF, 8'hFF};
        logic [9:0] y [4] = '{10'h080, 10'h200, 10'h3FC, 10'h1FE};
        apb(1'h1, REG_CONFIG, 32'h01);
        for (int i = 0; i < 4; i++) begin
            temp_code <= (i == 3) ? 8'hA1 : 8'h00;
            apb(1'h1, REG_MAIN_BRIGHT, {24'h0, b[i]});
            cyc(8);
            apb(1'h0, REG_STATE, 32'h0);
            check(rd[9:0], y[i]);
        end
        check(rd[18], 1'h1);
        temp_code <= 8'h00;
        $display("curve done");
    endtask
    task automatic t_pwm;
        apb(1'h1, REG_CONFIG, 32'h02);
        // Fastest output PWM so every fault wait spans a lit window
        apb(1'h1, REG_SHADOW + 12'h01C, 32'h3E);
        run <= 1'h1;
        cyc(25000);
        apb(1'h0, REG_STATE, 32'h0);
        check(rd[9:0] > 10'h1F4 && rd[9:0] < 10'h20C, 1'h1);
        apb(1'h0, REG_LIGHT, 32'h0);
        check(rd, 32'h5);
        open_flag <= 7'h01;
        cyc(6000);
        check(fault_n_oe, 1'h1);
        apb(1'h0, REG_FAULT, 32'h0);
        check(rd[0], 1'h1);
        open_flag <= 7'h00;
        apb(1'h1, REG_FAULT, 32'h7F);
        cyc(3);
        check(fault_n_oe, 1'h0);
        run <= 1'h0;
        cyc(6000);
        check({standby, sink_on[3:0]}, 32'h10);
        proto_sel <= 1'h0;
        run <= 1'h1;
        cyc(11000);
        check({standby, smbus_sel}, 32'h0);
        $display("pwm done");
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #800000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        cyc(2);
        t_regs();
        t_curve();
        t_pwm();
        wrap_up();
    end
endmodule
`default_nettype wire
